// ### rtl/bmcphy_top.sv
// biphase mark line coder, pin steering and receive path for the cc wire
//
// Overview of operation
// - toggle line at every bit cell start
// - one bits add a mid-cell toggle
// - preamble begins with line held low
// - receiver locks even without first edge
// - closing toggle after final end-of-packet bit
// - drive only orientation-selected channel pin
// - disparity stays within one bit
// - drive while sending, release when idle
// - single talker; others stay released
module bmcphy_top
	import bmcphy_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// orientation from attach detection
	input wire logic orient_flip,
	// transmit bit stream
	input wire logic tx_start,
	input wire logic tx_valid,
	input wire logic tx_data,
	input wire logic tx_last,
	output logic tx_ready_r,
	output logic tx_busy_r,
	// receive bit stream
	output logic rx_valid_r,
	output logic rx_data_r,
	output logic rx_end_r,
	// channel pins
	input wire logic config_channel_pin_a_in,
	input wire logic config_channel_pin_b_in,
	output bmc_pins_t pins_r
);
	// ****************************************
	// half-bit timebase
	// ****************************************
	logic [CNT_W-1:0] half_cnt_r;
	logic half_tick;
	bmc_tx_state_t state_r;
	bmc_tx_state_t state_nxt;
	logic level_r;
	logic phase_r;
	logic cur_bit_r;
	logic cur_last_r;
	logic have_bit_r;
	logic orient_r;
	logic config_channel_pin_selected;
	bmc_bit_t rx_bit;

	assign half_tick = (half_cnt_r == CNT_W'(HALF_BIT_CYC - 1));

	always_ff @(posedge clk_sys) begin
		if (sys_rst || state_r == BMC_TX_IDLE) begin
			half_cnt_r <= '0;
		end else if (half_tick) begin
			half_cnt_r <= '0;
		end else begin
			half_cnt_r <= half_cnt_r + CNT_W'(1);
		end
	end

	// ****************************************
	// transmit sequencer
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			BMC_TX_IDLE: begin
				if (tx_start) begin
					state_nxt = BMC_TX_LEAD;
				end
			end
			BMC_TX_LEAD: begin
				if (half_tick && phase_r) begin
					state_nxt = BMC_TX_DATA;
				end
			end
			BMC_TX_DATA: begin
				if (half_tick && phase_r && cur_last_r) begin
					state_nxt = BMC_TX_TAIL;
				end
			end
			BMC_TX_TAIL: begin
				if (half_tick) begin
					state_nxt = BMC_TX_IDLE;
				end
			end
			default: state_nxt = BMC_TX_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_r <= BMC_TX_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// phase: 0 = first half of cell, 1 = second half
	always_ff @(posedge clk_sys) begin
		if (sys_rst || state_r == BMC_TX_IDLE) begin
			phase_r <= 1'b0;
		end else if (half_tick) begin
			phase_r <= ~phase_r;
		end
	end

	// bit staging: next bit taken at the end of each cell
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cur_bit_r <= 1'b0;
			cur_last_r <= 1'b0;
			have_bit_r <= 1'b0;
			tx_ready_r <= 1'b0;
		end else begin
			tx_ready_r <= (state_r == BMC_TX_LEAD || state_r == BMC_TX_DATA)
				&& !have_bit_r && !tx_ready_r;
			if (tx_ready_r && tx_valid) begin
				have_bit_r <= 1'b1;
			end else if (half_tick && phase_r && state_r != BMC_TX_IDLE) begin
				have_bit_r <= 1'b0;
			end
			if (half_tick && phase_r && have_bit_r) begin
				cur_bit_r <= tx_data;
				cur_last_r <= tx_last;
			end
		end
	end
	// source must hold tx_data/tx_last once accepted until the cell end

	// line level
	always_ff @(posedge clk_sys) begin
		if (sys_rst || state_r == BMC_TX_IDLE) begin
			level_r <= LINE_LOW;
		end else if (half_tick) begin
			if (phase_r && state_r != BMC_TX_TAIL) begin
				// lead cell ends with the first edge; last data cell ends with the closing edge, tail holds
				level_r <= ~level_r;
			end else if (!phase_r && state_r == BMC_TX_DATA && cur_bit_r) begin
				level_r <= ~level_r;
			end
		end
	end
	// balanced one cells and alternating zero cells bound disparity to one bit

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tx_busy_r <= 1'b0;
			orient_r <= 1'b0;
		end else begin
			tx_busy_r <= (state_nxt != BMC_TX_IDLE);
			if (state_r == BMC_TX_IDLE) begin
				orient_r <= orient_flip;
			end
		end
	end

	// ****************************************
	// pin steering
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pins_r <= '{LINE_LOW, OE_RELEASE, LINE_LOW, OE_RELEASE};
		end else begin
			pins_r.pin_a_out <= level_r;
			pins_r.pin_b_out <= level_r;
			// lead cell holds low while driving, tail releases after closing edge
			pins_r.pin_a_oe_n <= (state_r != BMC_TX_IDLE && !orient_r)
				? OE_DRIVE : OE_RELEASE;
			pins_r.pin_b_oe_n <= (state_r != BMC_TX_IDLE && orient_r)
				? OE_DRIVE : OE_RELEASE;
		end
	end

	// ****************************************
	// receive path
	// ****************************************
	assign config_channel_pin_selected = orient_r ? config_channel_pin_b_in
		: config_channel_pin_a_in;

	// own transmission is not decoded
	bmc_rx u_rx (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.line_in(config_channel_pin_selected),
		.enable(state_r == BMC_TX_IDLE),
		.rx_bit(rx_bit)
	);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rx_valid_r <= 1'b0;
			rx_data_r <= 1'b0;
			rx_end_r <= 1'b0;
		end else begin
			rx_valid_r <= rx_bit.valid;
			rx_data_r <= rx_bit.data;
			rx_end_r <= rx_bit.last;
		end
	end
endmodule

// ### rtl/bmcphy_pkg.sv
// package for the biphase mark line coder and decoder
package bmcphy_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 100_000_000;
	localparam int BIT_RATE_HZ = 300_000;
	localparam int HALF_BIT_CYC = CLK_HZ / (2 * BIT_RATE_HZ);
	localparam int CNT_W = 16;
	// receiver: a toggle within this window around mid cell counts as a one
	localparam int MID_LO_CYC = (HALF_BIT_CYC * 3) / 4;
	localparam int MID_HI_CYC = (HALF_BIT_CYC * 5) / 4;
	// no edge for this long ends a received frame
	localparam int RX_IDLE_CYC = HALF_BIT_CYC * 4;
	// ****************************************
	// level and enable constants
	// ****************************************
	localparam logic LINE_LOW = 1'b0;
	localparam logic OE_DRIVE = 1'b0;
	localparam logic OE_RELEASE = 1'b1;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		BMC_TX_IDLE = 2'b00,
		BMC_TX_LEAD = 2'b01,
		BMC_TX_DATA = 2'b10,
		BMC_TX_TAIL = 2'b11
	} bmc_tx_state_t;

	typedef struct packed {
		logic pin_a_out;
		logic pin_a_oe_n;
		logic pin_b_out;
		logic pin_b_oe_n;
	} bmc_pins_t;

	typedef struct packed {
		logic valid;
		logic data;
		logic last;
	} bmc_bit_t;
endpackage

// ### rtl/bmc_rx.sv
// biphase mark decoder for one sampled line
module bmc_rx
	import bmcphy_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// line
	input wire logic line_in,
	input wire logic enable,
	// decoded bits
	output bmc_bit_t rx_bit
);
	logic prev_r;
	logic [CNT_W-1:0] cnt_r;
	logic locked_r;
	logic mid_seen_r;
	logic edge_w;

	assign edge_w = line_in ^ prev_r;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			prev_r <= LINE_LOW;
		end else begin
			prev_r <= line_in;
		end
	end

	// any edge may open the first cell, so a lost first edge only costs preamble bits
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !enable) begin
			cnt_r <= '0;
			locked_r <= 1'b0;
			mid_seen_r <= 1'b0;
			rx_bit <= '0;
		end else begin
			rx_bit <= '0;
			if (edge_w) begin
				if (locked_r && cnt_r >= CNT_W'(MID_LO_CYC) && cnt_r <= CNT_W'(MID_HI_CYC)
					&& !mid_seen_r) begin
					mid_seen_r <= 1'b1;
				end else begin
					if (locked_r) begin
						rx_bit.valid <= 1'b1;
						rx_bit.data <= mid_seen_r;
					end
					locked_r <= 1'b1;
					cnt_r <= '0;
					mid_seen_r <= 1'b0;
				end
			end else if (locked_r) begin
				if (cnt_r == CNT_W'(RX_IDLE_CYC)) begin
					locked_r <= 1'b0;
					rx_bit.last <= 1'b1;
				end else begin
					cnt_r <= cnt_r + CNT_W'(1);
				end
			end
		end
	end
endmodule

// ### verif/bmcphy_sva.sv
// port checker for the cc line coder
module bmcphy_sva
	import bmcphy_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// control
	input wire logic orient_flip,
	input wire logic tx_start,
	input wire logic tx_ready_r,
	input wire logic tx_busy_r,
	input wire logic rx_valid_r,
	// pins
	input bmc_pins_t pins_r
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	chk_one_pin: assert property (pins_r.pin_a_oe_n || pins_r.pin_b_oe_n)
		else $error("both pins driven");
	chk_pin_a_sel: assert property (tx_start && !tx_busy_r && !orient_flip |->
		##2 !pins_r.pin_a_oe_n) else $error("pin a not driven");
	chk_pin_b_sel: assert property (tx_start && !tx_busy_r && orient_flip |->
		##2 !pins_r.pin_b_oe_n) else $error("pin b not driven");
	chk_lead_low: assert property (tx_start && !tx_busy_r |->
		##2 (!pins_r.pin_a_out && !pins_r.pin_b_out) [*8]) else $error("lead not low");
	chk_start_busy: assert property (tx_start && !tx_busy_r |=> tx_busy_r)
		else $error("start ignored");
	chk_ready_busy: assert property (tx_ready_r |-> tx_busy_r) else $error("ready idle");
	chk_rx_mute: assert property (tx_busy_r |-> !rx_valid_r) else $error("rx while tx");
	chk_edge_hold: assert property (!pins_r.pin_a_oe_n && $changed(pins_r.pin_a_out) |=>
		$stable(pins_r.pin_a_out) [*8]) else $error("edge too soon");
	chk_rx_pulse: assert property (rx_valid_r |=> !rx_valid_r) else $error("rx not pulse");
endmodule

bind bmcphy_top bmcphy_sva u_sva (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.orient_flip(orient_flip), .tx_start(tx_start), .tx_ready_r(tx_ready_r),
	.tx_busy_r(tx_busy_r), .rx_valid_r(rx_valid_r), .pins_r(pins_r));

// ### verif/bmcphy_peer.sv
// peer controller sending one coded frame on the shared wire
module bmcphy_peer
	import bmcphy_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// line drive
	output logic drive,
	output logic lvl
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		drive = 1'b0;
		lvl = 1'b1;
	end
	task automatic half();
		repeat (HALF_BIT_CYC) @(posedge clk_sys);
		#1;
	endtask
	task automatic send(input logic [15:0] b);
		@(posedge clk_sys);
		#1;
		drive = 1'b1;
		lvl = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			// first cell edge is dropped on purpose
			if (i != 15) lvl = ~lvl;
			half();
			if (b[i]) lvl = ~lvl;
			half();
		end
		lvl = ~lvl;
		half();
		drive = 1'b0;
		lvl = 1'b1;
	endtask
endmodule

// ### verif/test_biphase_mark_cc_phy.sv
// bench for the cc line coder, pin steering and receiver
module test_biphase_mark_cc_phy
	import bmcphy_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, sys_rst = 1, orient_flip = 0, tx_start = 0;
	logic tx_valid = 0, tx_data = 0, tx_last = 0, wire_a, wire_b, peer_drive, peer_lvl;
	logic tx_ready_r, tx_busy_r, rx_valid_r, rx_data_r, rx_end_r;
	bmc_pins_t pins_r;
	int err_count = 0, samples_checked = 0;
	// released wire floats to the bias level
	assign wire_a = !pins_r.pin_a_oe_n ? pins_r.pin_a_out : (peer_drive ? peer_lvl : 1'b1);
	assign wire_b = !pins_r.pin_b_oe_n ? pins_r.pin_b_out : 1'b1;
	always #5 clk_sys = ~clk_sys;
	bmcphy_top u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .orient_flip(orient_flip),
		.tx_start(tx_start), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_ready_r(tx_ready_r), .tx_busy_r(tx_busy_r), .rx_valid_r(rx_valid_r),
		.rx_data_r(rx_data_r), .rx_end_r(rx_end_r), .config_channel_pin_a_in(wire_a),
		.config_channel_pin_b_in(wire_b), .pins_r(pins_r));
	bmcphy_peer u_peer (.clk_sys(clk_sys), .drive(peer_drive), .lvl(peer_lvl));
	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic note(input logic bad, input string m);
		samples_checked++;
		if (bad !== 1'b0) begin
			err_count++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task automatic tb_tx(input logic [7:0] b, input logic flip);
		int n = 0, edges = 0, disp = 0, lead = 0;
		logic prev, sel, oe, acc, on = 0;
		orient_flip = flip;
		tx_valid = 1;
		tx_data = b[7];
		tx_last = 0;
		tx_start = 1;
		for (int c = 0; c < 5000; c++) begin
			@(posedge clk_sys);
			sel = flip ? wire_b : wire_a;
			oe = flip ? pins_r.pin_b_oe_n : pins_r.pin_a_oe_n;
			if (on && oe) break;
			if (!oe && on && sel !== prev) edges++;
			if (edges > 0) disp += sel ? 1 : -1;
			else if (!oe) lead++;
			if (!oe) on = 1;
			prev = sel;
			acc = tx_ready_r && tx_valid;
			#1;
			tx_start = 0;
			// accepted bit must stand until the cell end loads it
			if (acc) begin
				tx_data = b[7 - (n & 7)];
				tx_last = n == 7;
				n++;
			end
			tx_valid = n < 8;
			if (c == 4999) note(1'b1, "tx hang");
			if (c == 4999) wrap_up();
		end
		note(edges !== 8 + $countones(b) + 1, "edge count");
		note(lead < 2 * HALF_BIT_CYC - 2, "lead short");
		note(disp > 2 * HALF_BIT_CYC + 4 || disp < -2 * HALF_BIT_CYC - 4, "disparity");
		$display("tx test done");
	endtask
	task automatic tb_rx();
		logic [7:0] got = 0;
		int cnt = 0;
		orient_flip = 0;
		fork
			u_peer.send(16'hAAC6);
			for (int c = 0; c < 8000; c++) begin
				@(posedge clk_sys);
				if (rx_valid_r === 1'b1) got = {got[6:0], rx_data_r};
				if (rx_valid_r === 1'b1) cnt++;
				if (rx_end_r === 1'b1) break;
				if (c == 7999) note(1'b1, "rx hang");
				if (c == 7999) wrap_up();
			end
		join
		note(got !== 8'hC6, "rx data");
		note(cnt < 8, "rx count");
		$display("rx test done");
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		#1;
		sys_rst = 0;
		@(posedge clk_sys);
		#1;
		tb_tx(8'hB2, 1'b0);
		tb_tx(8'h0F, 1'b1);
		tb_rx();
		wrap_up();
	end
endmodule
